// ---- rtl/bgc_pkg.sv ----
// constants and types for the battery gauge command map
package bgc_pkg;
   localparam logic [6:0] BGC_TARGET_ADDR = 7'h55;
   localparam logic [7:0] BGC_CODE_CONTROL = 8'h00;
   localparam logic [7:0] BGC_CODE_LOAD_RATE = 8'h02;
   localparam logic [7:0] BGC_CODE_LOAD_RUNTIME = 8'h04;
   localparam logic [7:0] BGC_CODE_TEMPERATURE = 8'h06;
   localparam logic [7:0] BGC_CODE_VOLTAGE = 8'h08;
   localparam logic [7:0] BGC_CODE_FLAGS = 8'h0a;
   localparam logic [7:0] BGC_CODE_UNC_REMAIN = 8'h0c;
   localparam logic [7:0] BGC_CODE_UNC_FULL = 8'h0e;
   localparam logic [7:0] BGC_CODE_COMP_REMAIN = 8'h10;
   localparam logic [7:0] BGC_CODE_COMP_FULL = 8'h12;
   localparam logic [7:0] BGC_CODE_MEAN_CUR = 8'h14;
   localparam logic [7:0] BGC_CODE_RUNTIME = 8'h16;
   localparam logic [7:0] BGC_CODE_IDLE_CUR = 8'h18;
   localparam logic [7:0] BGC_CODE_IDLE_RUNTIME = 8'h1a;
   localparam logic [7:0] BGC_CODE_HEALTH = 8'h1c;
   localparam logic [7:0] BGC_CODE_CYCLES = 8'h1e;
   localparam logic [7:0] BGC_CODE_CHARGE_PCT = 8'h20;
   localparam logic [7:0] BGC_CODE_MOM_CUR = 8'h22;
   localparam logic [7:0] BGC_CODE_DIE_TEMP = 8'h28;
   localparam logic [7:0] BGC_CODE_IMP_SCALE = 8'h2a;
   localparam logic [7:0] BGC_CODE_SETUP = 8'h2c;
   localparam logic [7:0] BGC_CODE_RATED_CAP = 8'h2e;
   localparam logic [7:0] BGC_CODE_READ_MAX = 8'h6b;
   localparam logic [15:0] BGC_RST_WORD = 16'h0000;
   localparam logic [3:0] BGC_BIT_LAST = 4'h7;
   localparam logic [1:0] BGC_TSRC_EXT = 2'h0;
   localparam logic [1:0] BGC_TSRC_DIE = 2'h1;
   localparam logic [1:0] BGC_TSRC_HOST = 2'h2;
   typedef enum logic [2:0] {
      BGC_PM_NORMAL, BGC_PM_LIGHT_SLEEP, BGC_PM_SLEEP, BGC_PM_HIBERNATE,
      BGC_PM_INSERTION_CHECK
   } bgc_pmode_e;
   typedef enum logic [2:0] {
      BGC_ST_IDLE, BGC_ST_RX, BGC_ST_ACK, BGC_ST_TX, BGC_ST_MACK, BGC_ST_NACK
   } bgc_state_e;
endpackage

// ---- rtl/bgc_gauge_map.sv ----
// i2c target and standard command map of the battery gauge
`timescale 1ns/10ps
// Overview of operation
// - each command is a 16-bit value on byte code pair 0x00 to 0x2f.
// - control pair 0x00/0x01 is writable in every access mode.
// - temperature writable even sealed; codes from 0x04 otherwise read-only.
// - voltage at 0x08/0x09 is read-only millivolts.
// - five power modes, moved by wake, idle, deep idle and cell-absent events.
// - temperature from thermistor, die sensor or host-written value.
// - nonvolatile locations closed to direct access in the field.
// - command pointer advances on every acknowledged data byte.
// - command byte selecting read above 0x6b is not acknowledged.
// - data byte written to a read-only code is not acknowledged.
module bgc_gauge_map
   import bgc_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   input wire logic [1:0] i_temp_source,
   input wire logic [15:0] i_ext_temperature,
   input wire logic [15:0] i_die_temperature,
   input wire logic [15:0] i_cell_voltage,
   input wire logic [15:0] i_flags,
   input wire logic [15:0] i_unc_remaining,
   input wire logic [15:0] i_unc_full,
   input wire logic [15:0] i_comp_remaining,
   input wire logic [15:0] i_comp_full,
   input wire logic [15:0] i_mean_current,
   input wire logic [15:0] i_runtime,
   input wire logic [15:0] i_idle_current,
   input wire logic [15:0] i_idle_runtime,
   input wire logic [15:0] i_health,
   input wire logic [15:0] i_cycles,
   input wire logic [15:0] i_charge_pct,
   input wire logic [15:0] i_mom_current,
   input wire logic [15:0] i_imp_scale,
   input wire logic [15:0] i_setup,
   input wire logic [15:0] i_rated_cap,
   input wire logic [15:0] i_load_runtime,
   input wire logic i_wake_event,
   input wire logic i_idle_event,
   input wire logic i_deep_idle_event,
   input wire logic i_cell_absent,
   output logic [15:0] o_control_subcommand,
   output logic o_control_strobe,
   output logic [15:0] o_load_rate,
   output logic [15:0] o_cell_temperature,
   output logic [2:0] o_power_mode
);
   // ------------------------------------------------------------
   // bus edge detection
   // ------------------------------------------------------------
   logic scl_q, sda_q;
   wire scl_rise = i_scl && !scl_q;
   wire scl_fall = !i_scl && scl_q;
   wire start_cond = scl_q && i_scl && sda_q && !i_sda;
   wire stop_cond = scl_q && i_scl && !sda_q && i_sda;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= i_scl;
         sda_q <= i_sda;
      end
   end

   // ------------------------------------------------------------
   // transfer state
   // ------------------------------------------------------------
   bgc_state_e state, next_state;
   logic [7:0] shreg;
   logic [3:0] bitcnt;
   logic [1:0] byte_idx;   // 0 address, 1 command code, 2+ data
   logic is_read;
   logic [7:0] ptr;
   logic [15:0] host_temp;
   logic [7:0] ctl_low;
   bgc_pmode_e pmode;

   wire [7:0] rx_byte = {shreg[6:0], i_sda};
   wire last_bit = (bitcnt == BGC_BIT_LAST);
   wire addr_hit = (rx_byte[7:1] == BGC_TARGET_ADDR);
   wire code_bad = (rx_byte > BGC_CODE_READ_MAX);
   // only control, load rate and temperature are writable, sealed or not
   wire ptr_writable = (ptr[7:2] == 6'h00) ||
                       (ptr[7:1] == BGC_CODE_TEMPERATURE[7:1]);

   // ------------------------------------------------------------
   // read data selection
   // ------------------------------------------------------------
   wire [15:0] temp_sel = (i_temp_source == BGC_TSRC_EXT) ? i_ext_temperature :
                          (i_temp_source == BGC_TSRC_DIE) ? i_die_temperature :
                          host_temp;
   logic [15:0] rd_word;
   always_comb begin
      rd_word = BGC_RST_WORD;
      case ({ptr[7:1], 1'b0})
         BGC_CODE_CONTROL: rd_word = o_control_subcommand;
         BGC_CODE_LOAD_RATE: rd_word = o_load_rate;
         BGC_CODE_LOAD_RUNTIME: rd_word = i_load_runtime;
         BGC_CODE_TEMPERATURE: rd_word = temp_sel;
         BGC_CODE_VOLTAGE: rd_word = i_cell_voltage;
         BGC_CODE_FLAGS: rd_word = i_flags;
         BGC_CODE_UNC_REMAIN: rd_word = i_unc_remaining;
         BGC_CODE_UNC_FULL: rd_word = i_unc_full;
         BGC_CODE_COMP_REMAIN: rd_word = i_comp_remaining;
         BGC_CODE_COMP_FULL: rd_word = i_comp_full;
         BGC_CODE_MEAN_CUR: rd_word = i_mean_current;
         BGC_CODE_RUNTIME: rd_word = i_runtime;
         BGC_CODE_IDLE_CUR: rd_word = i_idle_current;
         BGC_CODE_IDLE_RUNTIME: rd_word = i_idle_runtime;
         BGC_CODE_HEALTH: rd_word = i_health;
         BGC_CODE_CYCLES: rd_word = i_cycles;
         BGC_CODE_CHARGE_PCT: rd_word = i_charge_pct;
         BGC_CODE_MOM_CUR: rd_word = i_mom_current;
         BGC_CODE_DIE_TEMP: rd_word = i_die_temperature;
         BGC_CODE_IMP_SCALE: rd_word = i_imp_scale;
         BGC_CODE_SETUP: rd_word = i_setup;
         BGC_CODE_RATED_CAP: rd_word = i_rated_cap;
         // nonvolatile storage is not reachable through this map
         default: rd_word = BGC_RST_WORD;
      endcase
   end
   wire [7:0] rd_byte = ptr[0] ? rd_word[15:8] : rd_word[7:0];

   // ------------------------------------------------------------
   // protocol sequencing
   // ------------------------------------------------------------
   wire rx_done = (state == BGC_ST_RX) && scl_rise && last_bit;
   wire addr_phase = (byte_idx == 2'd0);
   wire code_phase = (byte_idx == 2'd1);
   wire wr_data_ok = rx_done && !addr_phase && !code_phase && ptr_writable;
   wire mack_seen = (state == BGC_ST_MACK) && scl_rise && !i_sda;

   always_comb begin
      next_state = state;
      unique case (state)
         BGC_ST_IDLE: next_state = state;
         BGC_ST_RX: begin
            if (rx_done) begin
               if (addr_phase)
                  next_state = addr_hit ? BGC_ST_ACK : BGC_ST_IDLE;
               else if (code_phase)
                  next_state = code_bad ? BGC_ST_NACK : BGC_ST_ACK;
               else
                  next_state = ptr_writable ? BGC_ST_ACK : BGC_ST_NACK;
            end
         end
         BGC_ST_ACK: begin
            if (scl_fall && bitcnt == 4'h1)
               next_state = is_read ? BGC_ST_TX : BGC_ST_RX;
         end
         BGC_ST_TX: begin
            if (scl_fall && last_bit)
               next_state = BGC_ST_MACK;
         end
         // host ack taken on the rise; next byte starts at the fall after it
         BGC_ST_MACK: begin
            if (scl_rise && i_sda)
               next_state = BGC_ST_IDLE;
            else if (scl_fall)
               next_state = BGC_ST_TX;
         end
         BGC_ST_NACK: begin
            if (scl_fall && bitcnt == 4'h1)
               next_state = BGC_ST_IDLE;
         end
      endcase
      if (start_cond)
         next_state = BGC_ST_RX;
      else if (stop_cond)
         next_state = BGC_ST_IDLE;
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= BGC_ST_IDLE;
         shreg <= 8'h00;
         bitcnt <= 4'h0;
         byte_idx <= 2'd0;
         is_read <= 1'b0;
         ptr <= 8'h00;
      end else begin
         state <= next_state;
         if (start_cond) begin
            bitcnt <= 4'h0;
            byte_idx <= 2'd0;
         end else if (state == BGC_ST_RX && scl_rise) begin
            shreg <= rx_byte;
            bitcnt <= last_bit ? 4'h0 : bitcnt + 4'h1;
            if (last_bit && addr_phase)
               is_read <= rx_byte[0];
            if (last_bit && code_phase)
               ptr <= rx_byte;
            if (last_bit && byte_idx != 2'd2)
               byte_idx <= byte_idx + 2'd1;
         end else if ((state == BGC_ST_ACK || state == BGC_ST_NACK) && scl_rise) begin
            bitcnt <= 4'h1;
            if (is_read && addr_phase == 1'b0)
               byte_idx <= 2'd2;
         end else if (state == BGC_ST_TX && scl_fall) begin
            bitcnt <= last_bit ? 4'h0 : bitcnt + 4'h1;
         end else if ((state == BGC_ST_ACK || state == BGC_ST_NACK) && scl_fall) begin
            bitcnt <= 4'h0;
         end
         // pointer steps on our ack of written data or host ack of read data
         if ((wr_data_ok) || mack_seen)
            ptr <= ptr + 8'h01;
      end
   end

   // target drives low for ack and for zero data bits; released otherwise
   // bit launched at a fall is the one after those already sent
   wire [3:0] tx_idx = (state == BGC_ST_TX) ? bitcnt + 4'h1 : 4'h0;
   wire tx_bit = rd_byte[3'(BGC_BIT_LAST - tx_idx)];
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_sda_oe <= 1'b0;
      end else if (scl_fall || start_cond || stop_cond) begin
         o_sda_oe <= (next_state == BGC_ST_ACK) ||
                     (next_state == BGC_ST_TX && !tx_bit);
      end
   end
   assign o_sda_out = 1'b0;

   // ------------------------------------------------------------
   // writable locations
   // ------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_control_subcommand <= BGC_RST_WORD;
         o_load_rate <= BGC_RST_WORD;
         host_temp <= BGC_RST_WORD;
         ctl_low <= 8'h00;
         o_control_strobe <= 1'b0;
      end else begin
         o_control_strobe <= 1'b0;
         if (wr_data_ok) begin
            unique case (ptr[2:0])
               3'd0: ctl_low <= rx_byte;
               3'd1: begin
                  o_control_subcommand <= {rx_byte, ctl_low};
                  o_control_strobe <= 1'b1;
               end
               3'd2: o_load_rate[7:0] <= rx_byte;
               3'd3: o_load_rate[15:8] <= rx_byte;
               3'd6: host_temp[7:0] <= rx_byte;
               3'd7: host_temp[15:8] <= rx_byte;
               default: ctl_low <= ctl_low;
            endcase
         end
      end
   end
   assign o_cell_temperature = temp_sel;

   // ------------------------------------------------------------
   // power modes
   // ------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         pmode <= BGC_PM_NORMAL;
      end else if (i_cell_absent) begin
         pmode <= BGC_PM_INSERTION_CHECK;
      end else if (i_wake_event) begin
         pmode <= BGC_PM_NORMAL;
      end else if (i_deep_idle_event) begin
         pmode <= BGC_PM_HIBERNATE;
      end else if (i_idle_event) begin
         pmode <= (pmode == BGC_PM_NORMAL) ? BGC_PM_LIGHT_SLEEP : BGC_PM_SLEEP;
      end else if (pmode == BGC_PM_INSERTION_CHECK) begin
         pmode <= BGC_PM_NORMAL;
      end
   end
   assign o_power_mode = pmode;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_bad_code_nack: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state == BGC_ST_RX && rx_done && code_phase && code_bad && !start_cond && !stop_cond)
      |=> state == BGC_ST_NACK) else $error("high read code acknowledged");
   a_ro_write_nack: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (rx_done && !addr_phase && !code_phase && !ptr_writable && !start_cond && !stop_cond)
      |=> state == BGC_ST_NACK) else $error("read-only write acknowledged");
   a_ptr_advance: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      mack_seen |=> ptr == $past(ptr) + 8'h01) else $error("pointer did not step");
   a_ctl_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (wr_data_ok && ptr == 8'h01) |=> o_control_strobe &&
      o_control_subcommand[15:8] == $past(rx_byte)) else $error("control not written");
   a_volt_readonly: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (ptr[7:1] == 7'h04) |-> !ptr_writable) else $error("voltage writable");
   a_addr_ignore: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (rx_done && addr_phase && !addr_hit && !start_cond && !stop_cond)
      |=> state == BGC_ST_IDLE) else $error("foreign address taken");
   a_host_temp: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (wr_data_ok && ptr == 8'h06) ##1 (i_temp_source == BGC_TSRC_HOST)
      |-> o_cell_temperature[7:0] == $past(rx_byte)) else $error("temp write lost");
   a_insert_mode: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_cell_absent |=> o_power_mode == BGC_PM_INSERTION_CHECK)
      else $error("insertion check missed");
endmodule

// ---- dv/bgc_host_model.sv ----
// i2c controller model standing in for the host processor
`timescale 1ns/10ps
module bgc_host_model #(
   parameter int LO = 260,
   parameter int HI = 240,
   parameter int BUF = 13200
) (
   input wire logic i_sys_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_pull
);
   bit bus_freed = 1'b0;
   initial begin
      o_scl = 1'b1;
      o_sda_pull = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge i_sys_clk);
   endtask
   // 1.3 us low plus 1.2 us high keeps scl at 400 kHz
   task automatic put_bit(input logic b, output logic seen);
      wait_clk(LO / 2);
      o_sda_pull = !b;
      wait_clk(LO - LO / 2);
      o_scl = 1'b1;
      wait_clk(HI / 2);
      seen = i_sda;
      wait_clk(HI - HI / 2);
      o_scl = 1'b0;
   endtask
   // serves as first and repeated start alike
   // bus free time honoured after a stop before anyone may start again
   task automatic start();
      if (bus_freed)
         wait_clk(BUF);
      bus_freed = 1'b0;
      wait_clk(LO / 2);
      o_sda_pull = 1'b0;
      wait_clk(LO - LO / 2);
      o_scl = 1'b1;
      wait_clk(HI / 2);
      o_sda_pull = 1'b1;
      wait_clk(HI - HI / 2);
      o_scl = 1'b0;
   endtask
   task automatic stop();
      wait_clk(LO / 2);
      o_sda_pull = 1'b1;
      wait_clk(LO - LO / 2);
      o_scl = 1'b1;
      wait_clk(HI / 2);
      o_sda_pull = 1'b0;
      bus_freed = 1'b1;
   endtask
   // tx of ff releases sda for reads; ack_out high lets the target answer
   task automatic xfer(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx,
      output logic ack_in);
      for (int i = 7; i >= 0; i--) begin
         put_bit(tx[i], rx[i]);
      end
      put_bit(ack_out, ack_in);
   endtask
endmodule

// ---- dv/battery_gauge_command_map_tb_top.sv ----
// self-checking testbench of the gauge command map
`timescale 1ns/10ps
module battery_gauge_command_map_tb_top;
   import bgc_pkg::*;
   logic sys_clk, rst, scl, host_pull, sda_out, sda_oe, strobe, ack, wake, idle, deep, absent;
   logic [1:0] tsrc;
   logic [2:0] mode;
   logic [7:0] rx;
   logic [15:0] ext_t, die_t, volt, ctl, rate, temp, lrt;
   logic [15:0] mv [0:15];
   wire sda;
   int miscompares = 0;
   int tests_run = 0;
   int strobes = 0;
   // open-drain wire with pull-up
   assign sda = !(host_pull || (sda_oe && !sda_out));
   bgc_host_model host (.i_sys_clk(sys_clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(host_pull));
   bgc_gauge_map dut (.i_sys_clk(sys_clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
      .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_temp_source(tsrc),
      .i_ext_temperature(ext_t), .i_die_temperature(die_t), .i_cell_voltage(volt),
      .i_flags(mv[0]), .i_unc_remaining(mv[1]), .i_unc_full(mv[2]), .i_comp_remaining(mv[3]),
      .i_comp_full(mv[4]), .i_mean_current(mv[5]), .i_runtime(mv[6]), .i_idle_current(mv[7]),
      .i_idle_runtime(mv[8]), .i_health(mv[9]), .i_cycles(mv[10]), .i_charge_pct(mv[11]),
      .i_mom_current(mv[12]), .i_imp_scale(mv[13]), .i_setup(mv[14]), .i_rated_cap(mv[15]),
      .i_load_runtime(lrt), .i_wake_event(wake), .i_idle_event(idle),
      .i_deep_idle_event(deep), .i_cell_absent(absent), .o_control_subcommand(ctl),
      .o_control_strobe(strobe), .o_load_rate(rate), .o_cell_temperature(temp),
      .o_power_mode(mode));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = !sys_clk;
   end
   always @(posedge sys_clk) if (strobe === 1'b1) strobes++;
   task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask
   task automatic send(input logic [7:0] b, input logic exp_nack);
      host.xfer(b, 1'b1, rx, ack);
      check16("ack bit", {15'h0, exp_nack}, {15'h0, ack});
   endtask
   task automatic report_and_stop();
      if (miscompares == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic test_reset();
      check16("control word", BGC_RST_WORD, ctl);
      check16("load rate", BGC_RST_WORD, rate);
      check16("power mode", 16'(BGC_PM_NORMAL), 16'(mode));
      check16("sda enable", 16'h0000, {15'h0, sda_oe});
   endtask
   task automatic test_power_modes();
      absent = 1'b1;
      host.wait_clk(3);
      check16("mode absent", 16'(BGC_PM_INSERTION_CHECK), 16'(mode));
      absent = 1'b0;
      host.wait_clk(3);
      check16("mode present", 16'(BGC_PM_NORMAL), 16'(mode));
      idle = 1'b1;
      host.wait_clk(1);
      check16("mode light sleep", 16'(BGC_PM_LIGHT_SLEEP), 16'(mode));
      host.wait_clk(1);
      check16("mode sleep", 16'(BGC_PM_SLEEP), 16'(mode));
      idle = 1'b0;
      deep = 1'b1;
      host.wait_clk(1);
      check16("mode hibernate", 16'(BGC_PM_HIBERNATE), 16'(mode));
      // wake outranks a deep idle event still standing
      wake = 1'b1;
      host.wait_clk(3);
      check16("mode woken", 16'(BGC_PM_NORMAL), 16'(mode));
      wake = 1'b0;
      deep = 1'b0;
   endtask
   // single-byte writes only, chained by repeated starts
   task automatic test_writes();
      tsrc = BGC_TSRC_HOST;
      host.start();
      send(8'haa, 1'b0);
      send(BGC_CODE_CONTROL + 8'h01, 1'b0);
      send(8'h12, 1'b0);
      host.start();
      send(8'haa, 1'b0);
      send(BGC_CODE_TEMPERATURE, 1'b0);
      send(8'h5a, 1'b0);
      host.start();
      send(8'haa, 1'b0);
      send(BGC_CODE_VOLTAGE, 1'b0);
      send(8'h3c, 1'b1);
      check16("control word", 16'h1200, ctl);
      check16("strobe count", 16'h0001, 16'(strobes));
      for (int s = 2; s < 4; s++) begin
         tsrc = 2'(s);
         host.wait_clk(1);
         check16("host temperature", 16'h005a, temp);
      end
      tsrc = BGC_TSRC_EXT;
      ext_t = 16'h0c08;
      host.wait_clk(1);
      check16("thermistor temperature", ext_t, temp);
      tsrc = BGC_TSRC_DIE;
      host.wait_clk(1);
      check16("die temperature", die_t, temp);
   endtask
   task automatic test_reads();
      string what [0:2];
      logic [15:0] exp_w [0:2];
      what[0] = "load runtime";
      what[1] = "temperature";
      what[2] = "voltage";
      exp_w[0] = lrt;
      exp_w[1] = die_t;
      exp_w[2] = volt;
      host.start();
      send(8'haa, 1'b0);
      send(BGC_CODE_LOAD_RUNTIME, 1'b0);
      host.start();
      send(8'hab, 1'b0);
      // incremental read over three pairs, host nack on the last byte
      for (int w = 0; w < 3; w++) begin
         host.xfer(8'hff, 1'b0, rx, ack);
         check16({what[w], " low byte"}, {8'h00, exp_w[w][7:0]}, {8'h00, rx});
         host.xfer(8'hff, w == 2, rx, ack);
         check16({what[w], " high byte"}, {8'h00, exp_w[w][15:8]}, {8'h00, rx});
      end
      host.start();
      send(8'haa, 1'b0);
      send(BGC_CODE_READ_MAX + 8'h01, 1'b1);
      host.start();
      send(8'ha8, 1'b1);
      host.stop();
   endtask
   initial begin
      // thermistor and die readings in tenths of a kelvin
      rst = 1'b1;
      tsrc = BGC_TSRC_EXT;
      ext_t = 16'h0bb8;
      die_t = 16'h0bc2;
      volt = 16'h0e74;
      lrt = 16'h00b4;
      {wake, idle, deep, absent} = 4'h0;
      for (int k = 0; k < 16; k++) mv[k] = 16'h1000 + 16'(k);
      repeat (5) @(negedge sys_clk);
      rst = 1'b0;
      host.wait_clk(2);
      test_reset();
      test_power_modes();
      test_writes();
      test_reads();
      report_and_stop();
   end
   // margin over the roughly 492 us that the sequence needs
   initial begin
      #520000;
      miscompares++;
      report_and_stop();
   end
endmodule
